// *** bench/move_instruction_execute_bench.sv ***
`include "mie_consts.svh"
`default_nettype none
module move_instruction_execute_bench
  import mie_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, instr_valid, ready_q, done_q, zero_q, zf;
  logic [`MIE_INSTR_W-1:0] instr, w;
  logic [7:0] acc_q, option_q, acc, opt;
  logic [7:0] mem [128];
  logic [16:0] expq [$];
  logic [16:0] e;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;
  int k;

  mie_move_exec dut (.clk(clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
    .ready_q(ready_q), .done_q(done_q), .acc_q(acc_q), .zero_q(zero_q), .option_q(option_q));

  // Bench clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Cycle ceiling so a stuck handshake cannot hang the run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      test_done();
    end
  end

  // Reference model plus driver; valid stays high between words to test refusal
  task automatic issue(input logic [13:0] wd);
    logic [6:0] a;
    logic [7:0] v;
    int n;
    a = wd[6:0];
    n = 0;
    if (wd[13:8] == `MIE_MOVE_OP) begin
      v = (a == `MIE_OPTION_ADDR) ? opt : mem[a];
      if (!wd[7]) acc = v;
      zf = (v == `MIE_ZERO_VAL);
    end else if (wd[13:7] == `MIE_STORE_OP) begin
      if (a == `MIE_OPTION_ADDR) opt = acc;
      else mem[a] = acc;
    end else if (wd == `MIE_OPTION_OPC) opt = acc;
    expq.push_back({acc, zf, opt});
    instr_valid = 1'b1;
    instr = wd;
    while (ready_q !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
  endtask

  // Watcher: oldest note against outputs when done pulses
  always @(negedge clk) begin
    if (rst_n && done_q === 1'b1) begin
      if (expq.size() == 0) begin
        check({7'h00, done_q}, 8'h00);
      end else begin
        e = expq.pop_front();
        check({7'h00, ready_q}, 8'h01);
        check(acc_q, e[16:9]);
        check({7'h00, zero_q}, {7'h00, e[8]});
        check(option_q, e[7:0]);
      end
    end
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    instr_valid = 1'b0;
    instr = '0;
    acc = `MIE_ACC_RST;
    opt = `MIE_OPTION_RST;
    zf = 1'b0;
    void'($urandom(32'h22a3));
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    check(acc_q, `MIE_ACC_RST);
    check(option_q, `MIE_OPTION_RST);
    check({7'h00, zero_q}, 8'h00);
    // Fill file space: low half zeros, high half ones from the option register
    for (int i = 0; i < 128; i++) begin
      if (i == 64) issue(14'h0801);
      if (i != 1) issue({7'h01, i[6:0]});
    end
    // Zero test by write-back, legacy load, option reached by address
    issue(14'h08a0);
    issue(14'h0820);
    issue(`MIE_OPTION_OPC);
    issue(14'h08c0);
    issue(14'h0840);
    issue(14'h0081);
    issue(14'h0801);
    // Random mix back to back; top bits 11 give words that must do nothing
    repeat (300) begin
      k = $urandom % 4;
      w = 14'($urandom);
      case (k)
        0: issue({6'h08, w[7:0]});
        1: issue({7'h01, w[6:0]});
        2: issue(`MIE_OPTION_OPC);
        default: issue({2'b11, w[11:0]});
      endcase
    end
    instr_valid = 1'b0;
    repeat (4) @(negedge clk);
    check(8'(expq.size()), 8'h00);
    test_done();
  end
endmodule
`default_nettype wire

// *** include/mie_consts.svh ***
`ifndef MIE_CONSTS_SVH
`define MIE_CONSTS_SVH

// Instruction word and data widths
`define MIE_INSTR_W 14
`define MIE_DATA_W 8
`define MIE_ADDR_W 7
`define MIE_MEM_DEPTH 128

// Opcode fields and fixed encodings
`define MIE_MOVE_OP 6'h08
`define MIE_STORE_OP 7'h01
`define MIE_OPTION_OPC 14'h0062

// File address at which the option register answers
`define MIE_OPTION_ADDR 7'h01

// Reset values
`define MIE_ACC_RST 8'h00
`define MIE_OPTION_RST 8'hff
`define MIE_ZERO_VAL 8'h00

`endif

// *** include/mie_pkg.sv ***
`include "mie_consts.svh"
`default_nettype none
package mie_pkg;

  // Execution sequencer, Gray coded
  typedef enum logic [1:0] {
    MIE_IDLE = 2'b00,
    MIE_EXEC = 2'b01
  } mie_state_t;

  // Fields of a move-class instruction word
  typedef struct packed {
    logic [5:0] op;
    logic dest;
    logic [`MIE_ADDR_W-1:0] addr;
  } mie_instr_t;

  // One write into the file register space
  typedef struct packed {
    logic en;
    logic [`MIE_ADDR_W-1:0] addr;
    logic [`MIE_DATA_W-1:0] data;
  } mie_wr_t;

endpackage
`default_nettype wire

// *** logic/mie_file_mem.sv ***
`include "mie_consts.svh"
`default_nettype none
module mie_file_mem
  import mie_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rd_en,
  input wire logic [`MIE_ADDR_W-1:0] rd_addr,
  output logic [`MIE_DATA_W-1:0] rd_data_q,
  input wire mie_wr_t wr
);

  logic [`MIE_DATA_W-1:0] mem_q [0:`MIE_MEM_DEPTH-1];

  // Storage has no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (wr.en) begin
      mem_q[wr.addr] <= wr.data;
    end
  end

  // Registered read port, one clock of latency
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_q <= `MIE_ZERO_VAL;
    end else if (rd_en) begin
      rd_data_q <= mem_q[rd_addr];
    end
  end

endmodule
`default_nettype wire

// *** logic/mie_move_exec.sv ***
`include "mie_consts.svh"
`default_nettype none
// Operation
// RULE1 - Move-from-file with target clear loads the addressed register into accumulator.
// RULE2 - Move-from-file with target set writes the value back, accumulator kept.
// RULE3 - Move-from-file updates the zero flag whichever target is chosen.
// RULE4 - Store-accumulator writes accumulator into addressed register, flags unchanged.
// RULE5 - Fixed load-option opcode copies accumulator to option register in one cycle; here it takes one two-clock instruction slot.
// RULE6 - Option register is also an ordinary addressed file register.
// RULE7 - Zero flag set when moved byte is zero, cleared otherwise.
module mie_move_exec
  import mie_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [`MIE_INSTR_W-1:0] instr,
  output logic ready_q,
  output logic done_q,
  output logic [`MIE_DATA_W-1:0] acc_q,
  output logic zero_q,
  output logic [`MIE_DATA_W-1:0] option_q
);

  mie_state_t state_q;
  mie_state_t state_d;
  mie_instr_t instr_q;
  logic [`MIE_DATA_W-1:0] mem_rd_data;
  mie_wr_t wr;
  mie_wr_t mem_wr;

  // Accept handshake and decode of the held word
  wire accept = instr_valid && ready_q;
  wire exec = (state_q == MIE_EXEC);
  wire is_move = (instr_q.op == `MIE_MOVE_OP);
  wire is_store = ({instr_q.op, instr_q.dest} == `MIE_STORE_OP);
  wire is_option = (instr_q == `MIE_OPTION_OPC);
  wire hits_option = (instr_q.addr == `MIE_OPTION_ADDR);

  // Operand: option register overlays its file address
  wire [`MIE_DATA_W-1:0] rd_val = hits_option ? option_q : mem_rd_data; // see RULE6
  wire rd_zero = (rd_val == `MIE_ZERO_VAL); // see RULE7

  // File write: store of accumulator, or write-back of moved value
  wire wr_store = exec && is_store; // see RULE4
  wire wr_back = exec && is_move && instr_q.dest; // see RULE2
  assign wr.en = wr_store || wr_back;
  assign wr.addr = instr_q.addr;
  assign wr.data = wr_store ? acc_q : rd_val;

  // Writes to the option address never reach the array, so no stale copy
  assign mem_wr.en = wr.en && !hits_option; // see RULE6
  assign mem_wr.addr = wr.addr;
  assign mem_wr.data = wr.data;
  wire opt_wr = (exec && is_option) || (wr.en && hits_option); // see RULE5
  wire [`MIE_DATA_W-1:0] opt_wr_data = is_option ? acc_q : wr.data;

  // Accumulator and zero flag updates
  wire acc_ld = exec && is_move && !instr_q.dest; // see RULE1
  wire zero_ld = exec && is_move; // see RULE3

  // Two clocks per instruction: operand read, then execute
  always_comb begin
    case (state_q)
      MIE_IDLE: state_d = accept ? MIE_EXEC : MIE_IDLE;
      MIE_EXEC: state_d = MIE_IDLE;
      default: state_d = MIE_IDLE;
    endcase
  end

  mie_file_mem u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .rd_en(accept),
    .rd_addr(instr[`MIE_ADDR_W-1:0]),
    .rd_data_q(mem_rd_data),
    .wr(mem_wr)
  );

  // Sequencer and instruction hold
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= MIE_IDLE;
      instr_q <= '0;
      ready_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (accept) begin
        instr_q <= instr;
      end
      ready_q <= !accept;
      done_q <= exec;
    end
  end

  // Architectural state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q <= `MIE_ACC_RST;
      zero_q <= 1'b0;
      option_q <= `MIE_OPTION_RST;
    end else begin
      if (acc_ld) begin
        acc_q <= rd_val; // see RULE1
      end
      if (zero_ld) begin
        zero_q <= rd_zero; // see RULE3
      end
      if (opt_wr) begin
        option_q <= opt_wr_data; // see RULE5
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  load_to_acc_a: assert property ( // see RULE1
    exec && is_move && !instr_q.dest |=> acc_q == $past(rd_val))
    else $error("accumulator not loaded by move-from-file");

  move_back_a: assert property ( // see RULE2
    exec && is_move && instr_q.dest |-> wr.en && wr.addr == instr_q.addr
      && wr.data == rd_val ##1 $stable(acc_q))
    else $error("write-back of moved value wrong");

  back_zero_a: assert property ( // see RULE3
    exec && is_move && instr_q.dest |=> zero_q == ($past(rd_val) == `MIE_ZERO_VAL))
    else $error("zero flag not updated on write-back");

  zero_value_a: assert property ( // see RULE7
    exec && is_move |=> zero_q == ($past(rd_val) == `MIE_ZERO_VAL))
    else $error("zero flag does not match moved byte");

  store_acc_a: assert property ( // see RULE4
    exec && is_store |-> wr.en && wr.data == acc_q ##1 $stable(zero_q))
    else $error("store-accumulator wrong or touched flag");

  option_load_a: assert property ( // see RULE5
    accept && instr == `MIE_OPTION_OPC |-> ##2 option_q == $past(acc_q, 1)
      && $stable(zero_q) && done_q)
    else $error("load-option did not complete in one instruction");

  option_addr_rd_a: assert property ( // see RULE6
    exec && is_move && !instr_q.dest && hits_option |=> acc_q == $past(option_q))
    else $error("option register not readable at its address");

  option_addr_wr_a: assert property ( // see RULE6
    exec && is_store && hits_option |-> !mem_wr.en ##1 option_q == $past(acc_q))
    else $error("option register not writable at its address");

  handshake_a: assert property ( // see RULE5
    accept |=> !ready_q && exec ##1 ready_q && done_q)
    else $error("instruction slot not two clocks");

  // Accumulator moves only on a move-from-file to the accumulator
  acc_hold_a: assert property ( // see RULE2
    !(exec && is_move && !instr_q.dest) |=> $stable(acc_q))
    else $error("accumulator changed without a load");

  // Store and load-option leave the zero flag alone
  zero_hold_a: assert property ( // see RULE4
    !(exec && is_move) |=> $stable(zero_q))
    else $error("zero flag changed outside move-from-file");

  // Option moves only on load-option or a store to its address
  option_hold_a: assert property ( // see RULE6
    !(exec && (is_option || is_store && hits_option)) |=> $stable(option_q))
    else $error("option register changed unexpectedly");

  // Store reaches the array at the coded address with the accumulator
  store_target_a: assert property ( // see RULE4
    exec && is_store && !hits_option |-> mem_wr.en && mem_wr.addr == instr_q.addr
      && mem_wr.data == acc_q)
    else $error("store did not reach the file array");

  // Write-back of an array register returns its own value
  back_target_a: assert property ( // see RULE2
    exec && is_move && instr_q.dest && !hits_option |-> mem_wr.en
      && mem_wr.addr == instr_q.addr && mem_wr.data == mem_rd_data)
    else $error("write-back did not return the read value");

  // No array write outside a store or a write-back
  write_quiet_a: assert property ( // see RULE1
    !(exec && (is_store || is_move && instr_q.dest)) |-> !mem_wr.en)
    else $error("file array written without cause");

  // The option address never lands in the array
  option_overlay_a: assert property ( // see RULE6
    mem_wr.en |-> mem_wr.addr != `MIE_OPTION_ADDR)
    else $error("option address written into the array");

  // Load-option copies the accumulator at the execute edge
  option_exec_a: assert property ( // see RULE5
    exec && is_option |=> option_q == $past(acc_q))
    else $error("load-option did not copy the accumulator");

  // Write-back to the option address keeps its value
  option_back_a: assert property ( // see RULE6
    exec && is_move && instr_q.dest && hits_option |=> $stable(option_q) && $stable(acc_q))
    else $error("write-back to option register changed state");

  // Load with target clear must not write the file
  load_no_write_a: assert property ( // see RULE1
    exec && is_move && !instr_q.dest |-> !wr.en)
    else $error("load to accumulator wrote the file");

  // Held word changes only on an accepted offer
  word_hold_a: assert property ( // see RULE1
    !accept |=> $stable(instr_q))
    else $error("held instruction changed without accept");

  // No new word is taken while one executes
  exec_ready_a: assert property ( // see RULE5
    exec |-> !ready_q)
    else $error("ready raised during execute");

  // Every execute is followed by a single done pulse
  exec_done_a: assert property ( // see RULE5
    exec |=> done_q)
    else $error("done did not follow execute");

  done_pulse_a: assert property ( // see RULE5
    done_q |=> !done_q)
    else $error("done held longer than one clock");

endmodule
`default_nettype wire
